// *** hw/wdttd_counter.sv ***
// watchdog counter in the watchdog oscillator domain
`timescale 1ns/1ps
`default_nettype none
module wdttd_counter import wdttd_pkg::*; #(
   parameter int unsigned BASE_TIMEOUT = BASE_TIMEOUT_DEF,
   parameter int unsigned CNT_W = CNT_W_DEF
) (
   // oscillator clock and reset
   input wire logic wdt_osc_in,
   input wire logic arst_n_in,
   // synchronised controls, and select data held stable by the request handshake
   input wire logic enable_in,
   input wire logic restart_req_in,
   input wire logic tsel_req_in,
   input wire logic [TSEL_W-1:0] tsel_data_in,
   // answers
   output logic restart_ack_out,
   output logic tsel_ack_out,
   output logic timeout_tgl_out
);
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic [TSEL_W-1:0] tsel_r, tsel_nxt;
   logic rack_r, rack_nxt;
   logic sack_r, sack_nxt;
   logic tgl_r, tgl_nxt;
   logic [CNT_W-1:0] limit;

   always_comb begin
      limit = CNT_W'(BASE_TIMEOUT) << tsel_r;
      cnt_nxt = cnt_r;
      tsel_nxt = tsel_r;
      tgl_nxt = tgl_r;
      rack_nxt = restart_req_in;
      sack_nxt = tsel_req_in;
      if (tsel_req_in != sack_r) begin
         tsel_nxt = tsel_data_in;
      end
      if (restart_req_in != rack_r) begin
         cnt_nxt = '0;
      end else if (enable_in) begin
         if (cnt_r == limit - 1'b1) begin
            cnt_nxt = '0;
            tgl_nxt = ~tgl_r;
         end else begin
            cnt_nxt = cnt_r + 1'b1;
         end
      end
   end

   always_ff @(posedge wdt_osc_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cnt_r <= '0;
         tsel_r <= '0;
         tgl_r <= 1'b0;
         rack_r <= 1'b0;
         sack_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         tsel_r <= tsel_nxt;
         tgl_r <= tgl_nxt;
         rack_r <= rack_nxt;
         sack_r <= sack_nxt;
      end
   end

   assign restart_ack_out = rack_r;
   assign tsel_ack_out = sack_r;
   assign timeout_tgl_out = tgl_r;
endmodule
`default_nettype wire

// *** hw/wdttd_pkg.sv ***
// shared constants for the watchdog timer with timed disable
package wdttd_pkg;
   // register bus
   localparam int unsigned ADDR_W = 4;
   localparam logic [3:0] CTRL_OFFS = 4'h0;
   localparam logic [3:0] STAT_OFFS = 4'h4;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // decoded register selects
   localparam logic [1:0] SEL_CTRL = 2'h0;
   localparam logic [1:0] SEL_STAT = 2'h1;
   localparam logic [1:0] SEL_NONE = 2'h2;
   // watchdog_control fields
   localparam int unsigned UNLOCK_BIT = 4;
   localparam int unsigned ENABLE_BIT = 3;
   localparam int unsigned TSEL_LSB = 0;
   localparam int unsigned TSEL_W = 3;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // status fields
   localparam int unsigned STAT_TIMEOUT_BIT = 0;
   localparam int unsigned STAT_BUSY_BIT = 1;
   // unlock window in main clock cycles
   localparam int unsigned UNLOCK_CYCLES = 4;
   localparam logic [2:0] UNLOCK_LOAD = 3'(UNLOCK_CYCLES - 1);
   // shortest timeout in watchdog oscillator cycles, and counter width for the longest
   localparam int unsigned BASE_TIMEOUT_DEF = 16384;
   localparam int unsigned CNT_W_DEF = 22;
endpackage

// *** hw/wdttd_sync.sv ***
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module wdttd_sync #(
   parameter int unsigned W = 1
) (
   // clock and reset of the receiving domain
   input wire logic clk_in,
   input wire logic arst_n_in,
   // data
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] meta_r;
   logic [W-1:0] q_r;

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         meta_r <= '0;
         q_r <= '0;
      end else begin
         meta_r <= d_in;
         q_r <= meta_r;
      end
   end

   assign q_out = q_r;
endmodule
`default_nettype wire

// *** hw/wdttd_top.sv ***
// watchdog timer with timed disable: register slave and domain crossings
//
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module wdttd_top import wdttd_pkg::*; #(
   parameter int unsigned BASE_TIMEOUT = BASE_TIMEOUT_DEF,
   parameter int unsigned CNT_W = CNT_W_DEF
) (
   // clocks and reset
   input wire logic clk_in,
   input wire logic wdt_osc_in,
   input wire logic arst_n_in,
   // core side
   input wire logic watchdog_restart_instr_in,
   output logic wdt_reset_out,
   // axi4-lite write address
   input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
   input wire logic [2:0] s_axi_awprot_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   // axi4-lite read address
   input wire logic [ADDR_W-1:0] s_axi_araddr_in,
   input wire logic [2:0] s_axi_arprot_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in
);
   function automatic logic [1:0] reg_decode(input logic [ADDR_W-1:0] addr);
      if (addr[ADDR_W-1:2] == CTRL_OFFS[ADDR_W-1:2]) begin
         return SEL_CTRL;
      end else if (addr[ADDR_W-1:2] == STAT_OFFS[ADDR_W-1:2]) begin
         return SEL_STAT;
      end
      return SEL_NONE;
   endfunction

   // bus state
   logic aw_full_r, aw_full_nxt;
   logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
   logic w_full_r, w_full_nxt;
   logic [31:0] w_data_r, w_data_nxt;
   logic [3:0] w_strb_r, w_strb_nxt;
   logic bvalid_r, bvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [1:0] rresp_r, rresp_nxt;
   logic do_wr;
   logic [1:0] wr_sel;
   logic [1:0] rd_sel;

   // control and status state
   logic enable_r, enable_nxt;
   logic unlock_r, unlock_nxt;
   logic [2:0] unlock_cnt_r, unlock_cnt_nxt;
   logic [TSEL_W-1:0] tsel_r, tsel_nxt;
   logic timeout_flag_r, timeout_flag_nxt;
   logic wr_ctrl, wr_stat;
   logic [7:0] ctrl_view;
   logic [7:0] stat_view;

   // crossing state
   logic restart_pend_r, restart_pend_nxt;
   logic restart_req_r, restart_req_nxt;
   logic tsel_req_r, tsel_req_nxt;
   logic [TSEL_W-1:0] tsel_hold_r, tsel_hold_nxt;
   logic timeout_seen_r, timeout_seen_nxt;
   logic reset_pulse_r, reset_pulse_nxt;
   logic enable_s, restart_req_s, tsel_req_s;
   logic restart_ack, tsel_ack, timeout_tgl;
   logic restart_ack_s, tsel_ack_s, timeout_tgl_s;
   logic timeout_evt;

   assign s_axi_awready_out = !aw_full_r;
   assign s_axi_wready_out = !w_full_r;
   assign s_axi_arready_out = !rvalid_r;
   assign do_wr = aw_full_r && w_full_r && !bvalid_r;
   assign wr_sel = reg_decode(aw_addr_r);
   assign rd_sel = reg_decode(s_axi_araddr_in);
   assign wr_ctrl = do_wr && (wr_sel == SEL_CTRL) && w_strb_r[0];
   assign wr_stat = do_wr && (wr_sel == SEL_STAT) && w_strb_r[0];

   assign ctrl_view = {3'h0, unlock_r, enable_r, tsel_r};
   assign stat_view = {6'h00, restart_pend_r || (restart_req_r != restart_ack_s),
                       timeout_flag_r};

   // bus handshakes
   always_comb begin
      aw_full_nxt = aw_full_r;
      aw_addr_nxt = aw_addr_r;
      w_full_nxt = w_full_r;
      w_data_nxt = w_data_r;
      w_strb_nxt = w_strb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (s_axi_awvalid_in && !aw_full_r) begin
         aw_full_nxt = 1'b1;
         aw_addr_nxt = s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && !w_full_r) begin
         w_full_nxt = 1'b1;
         w_data_nxt = s_axi_wdata_in;
         w_strb_nxt = s_axi_wstrb_in;
      end
      if (do_wr) begin
         aw_full_nxt = 1'b0;
         w_full_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (bvalid_r && s_axi_bready_in) begin
         bvalid_nxt = 1'b0;
      end
      if (s_axi_arvalid_in && !rvalid_r) begin
         rvalid_nxt = 1'b1;
         rresp_nxt = RESP_OKAY;
         case (rd_sel)
            SEL_CTRL: rdata_nxt = {24'h000000, ctrl_view};
            SEL_STAT: rdata_nxt = {24'h000000, stat_view};
            default: begin
               rdata_nxt = 32'h00000000;
               rresp_nxt = RESP_SLVERR;
            end
         endcase
      end else if (rvalid_r && s_axi_rready_in) begin
         rvalid_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         aw_full_r <= 1'b0;
         aw_addr_r <= '0;
         w_full_r <= 1'b0;
         w_data_r <= 32'h00000000;
         w_strb_r <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h00000000;
         rresp_r <= RESP_OKAY;
      end else begin
         aw_full_r <= aw_full_nxt;
         aw_addr_r <= aw_addr_nxt;
         w_full_r <= w_full_nxt;
         w_data_r <= w_data_nxt;
         w_strb_r <= w_strb_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end
   end

   assign s_axi_bvalid_out = bvalid_r;
   assign s_axi_bresp_out = bresp_r;
   assign s_axi_rvalid_out = rvalid_r;
   assign s_axi_rdata_out = rdata_r;
   assign s_axi_rresp_out = rresp_r;

   // control register, unlock window and timeout flag
   always_comb begin
      enable_nxt = enable_r;
      unlock_nxt = unlock_r;
      unlock_cnt_nxt = unlock_cnt_r;
      tsel_nxt = tsel_r;
      timeout_flag_nxt = timeout_flag_r;
      if (unlock_r) begin
         if (unlock_cnt_r == 3'h0) begin
            unlock_nxt = 1'b0;
         end else begin
            unlock_cnt_nxt = unlock_cnt_r - 3'h1;
         end
      end
      if (wr_ctrl) begin
         tsel_nxt = w_data_r[TSEL_LSB +: TSEL_W];
         if (w_data_r[ENABLE_BIT]) begin
            enable_nxt = 1'b1;
            if (w_data_r[UNLOCK_BIT]) begin
               unlock_nxt = 1'b1;
               unlock_cnt_nxt = UNLOCK_LOAD;
            end
         end else if (unlock_r) begin
            enable_nxt = 1'b0;
         end
      end
      if (wr_stat && w_data_r[STAT_TIMEOUT_BIT]) begin
         timeout_flag_nxt = 1'b0;
      end
      if (timeout_evt) begin
         timeout_flag_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         enable_r <= CTRL_RESET[ENABLE_BIT];
         unlock_r <= CTRL_RESET[UNLOCK_BIT];
         unlock_cnt_r <= 3'h0;
         tsel_r <= CTRL_RESET[TSEL_LSB +: TSEL_W];
         timeout_flag_r <= 1'b0;
      end else begin
         enable_r <= enable_nxt;
         unlock_r <= unlock_nxt;
         unlock_cnt_r <= unlock_cnt_nxt;
         tsel_r <= tsel_nxt;
         timeout_flag_r <= timeout_flag_nxt;
      end
   end

   // request handshakes toward the oscillator domain
   always_comb begin
      restart_pend_nxt = restart_pend_r;
      restart_req_nxt = restart_req_r;
      tsel_req_nxt = tsel_req_r;
      tsel_hold_nxt = tsel_hold_r;
      if (restart_pend_r && (restart_req_r == restart_ack_s)) begin
         restart_req_nxt = ~restart_req_r;
         restart_pend_nxt = 1'b0;
      end
      if (watchdog_restart_instr_in) begin
         restart_pend_nxt = 1'b1;
      end
      if ((tsel_req_r == tsel_ack_s) && (tsel_hold_r != tsel_r)) begin
         tsel_hold_nxt = tsel_r;
         tsel_req_nxt = ~tsel_req_r;
      end
      timeout_seen_nxt = timeout_tgl_s;
      reset_pulse_nxt = timeout_evt;
   end

   assign timeout_evt = timeout_tgl_s != timeout_seen_r;

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         restart_pend_r <= 1'b0;
         restart_req_r <= 1'b0;
         tsel_req_r <= 1'b0;
         tsel_hold_r <= '0;
         timeout_seen_r <= 1'b0;
         reset_pulse_r <= 1'b0;
      end else begin
         restart_pend_r <= restart_pend_nxt;
         restart_req_r <= restart_req_nxt;
         tsel_req_r <= tsel_req_nxt;
         tsel_hold_r <= tsel_hold_nxt;
         timeout_seen_r <= timeout_seen_nxt;
         reset_pulse_r <= reset_pulse_nxt;
      end
   end

   assign wdt_reset_out = reset_pulse_r;

   // main clock to oscillator crossings
   wdttd_sync #(.W(3)) u_to_osc (
      .clk_in(wdt_osc_in),
      .arst_n_in(arst_n_in),
      .d_in({enable_r, restart_req_r, tsel_req_r}),
      .q_out({enable_s, restart_req_s, tsel_req_s})
   );

   // oscillator to main clock crossings
   wdttd_sync #(.W(3)) u_to_clk (
      .clk_in(clk_in),
      .arst_n_in(arst_n_in),
      .d_in({restart_ack, tsel_ack, timeout_tgl}),
      .q_out({restart_ack_s, tsel_ack_s, timeout_tgl_s})
   );

   wdttd_counter #(
      .BASE_TIMEOUT(BASE_TIMEOUT),
      .CNT_W(CNT_W)
   ) u_counter (
      .wdt_osc_in(wdt_osc_in),
      .arst_n_in(arst_n_in),
      .enable_in(enable_s),
      .restart_req_in(restart_req_s),
      .tsel_req_in(tsel_req_s),
      .tsel_data_in(tsel_hold_r),
      .restart_ack_out(restart_ack),
      .tsel_ack_out(tsel_ack),
      .timeout_tgl_out(timeout_tgl)
   );
endmodule
`default_nettype wire

// *** tb/wdttd_core_model.sv ***
// core model that issues watchdog restart instructions
`timescale 1ns/1ps
`default_nettype none
module wdttd_core_model #(
   parameter int unsigned GAP = 20
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic arst_n_in,
   // requests from the bench
   input wire logic kick_en_in,
   input wire logic kick_one_in,
   // restart instruction pulse
   output logic restart_out
);
   int unsigned cnt_r;
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cnt_r <= 0;
         restart_out <= 1'b0;
      end else begin
         cnt_r <= (cnt_r == GAP - 1) ? 0 : cnt_r + 1;
         // single restart, or periodic while kicking
         restart_out <= kick_one_in || (kick_en_in && cnt_r == GAP - 1);
      end
   end
endmodule
`default_nettype wire

// *** tb/wdttd_top_properties.sv ***
// assertion checker bound to the watchdog top module
`timescale 1ns/1ps
`default_nettype none
module wdttd_top_properties (
   // clock and reset
   input wire logic clk_in,
   input wire logic arst_n_in,
   // core side
   input wire logic wdt_reset_out,
   // register bus
   input wire logic s_axi_awvalid_in,
   input wire logic s_axi_awready_out,
   input wire logic s_axi_wvalid_in,
   input wire logic s_axi_wready_out,
   input wire logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic s_axi_arvalid_in,
   input wire logic s_axi_arready_out,
   input wire logic [31:0] s_axi_rdata_out,
   input wire logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   logic wr_seen_r;
   logic wr_seen_nxt;
   // no write yet means the watchdog was never enabled
   always_comb begin
      wr_seen_nxt = wr_seen_r | (s_axi_wvalid_in & s_axi_wready_out);
   end
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wr_seen_r <= 1'b0;
      end else begin
         wr_seen_r <= wr_seen_nxt;
      end
   end
   rsvd_zero_a: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:5] == 27'h0)
      else $error("reserved read bits not zero");
   reset_pulse_a: assert property (wdt_reset_out |=> !wdt_reset_out)
      else $error("system reset pulse longer than one cycle");
   quiet_off_a: assert property (!wr_seen_r |-> !wdt_reset_out)
      else $error("reset issued while never enabled");
   rd_lat_a: assert property (s_axi_arvalid_in && s_axi_arready_out |=>
      s_axi_rvalid_out && !s_axi_arready_out)
      else $error("read answer late or address not refused");
   rd_done_a: assert property (s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out)
      else $error("read data held after acceptance");
   b_done_a: assert property (s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out)
      else $error("write response held after acceptance");
   wr_lat_a: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in &&
      s_axi_wready_out && !s_axi_bvalid_out |-> ##2 s_axi_bvalid_out)
      else $error("write response not two cycles after transfer");
   wr_refuse_a: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in &&
      s_axi_wready_out |=> !s_axi_awready_out && !s_axi_wready_out)
      else $error("write channels not refused while busy");
endmodule
bind wdttd_top wdttd_top_properties u_props (.clk_in, .arst_n_in, .wdt_reset_out,
   .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out,
   .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_arvalid_in, .s_axi_arready_out,
   .s_axi_rdata_out, .s_axi_rvalid_out, .s_axi_rready_in);
`default_nettype wire

// *** tb/wdttd_top_tb.sv ***
// self-checking bench for the watchdog timer with timed disable
`timescale 1ns/1ps
`default_nettype none
module wdttd_top_tb import wdttd_pkg::*;;
   localparam int unsigned BASE = 16;
   localparam int unsigned OSC_NS = 10;
   logic clk_in, wdt_osc_in, arst_n_in, watchdog_restart_instr_in, wdt_reset_out;
   logic [3:0] s_axi_awaddr_in, s_axi_araddr_in, s_axi_wstrb_in;
   logic [2:0] s_axi_awprot_in, s_axi_arprot_in;
   logic [31:0] s_axi_wdata_in, s_axi_rdata_out, d;
   logic [1:0] s_axi_bresp_out, s_axi_rresp_out, r;
   logic s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out;
   logic s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out;
   logic s_axi_rvalid_out, s_axi_rready_in, kick_en, kick_one;
   int n_fail, n_compared, n_rst, k;
   realtime t0, t1;
   wdttd_top #(.BASE_TIMEOUT(BASE), .CNT_W(12)) dut (
      .clk_in, .wdt_osc_in, .arst_n_in, .watchdog_restart_instr_in, .wdt_reset_out,
      .s_axi_awaddr_in, .s_axi_awprot_in, .s_axi_awvalid_in, .s_axi_awready_out,
      .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out,
      .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
      .s_axi_araddr_in, .s_axi_arprot_in, .s_axi_arvalid_in, .s_axi_arready_out,
      .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in);
   wdttd_core_model #(.GAP(20)) core (.clk_in, .arst_n_in, .kick_en_in(kick_en),
      .kick_one_in(kick_one), .restart_out(watchdog_restart_instr_in));
   always #2 clk_in = ~clk_in;
   initial begin
      wdt_osc_in = 1'b0;
      #1.3;
      forever #5 wdt_osc_in = ~wdt_osc_in;
   end
   always @(negedge clk_in) if (wdt_reset_out === 1'b1) n_rst++;
   function automatic logic [31:0] exp_ns(input int s);
      return 32'((BASE << s) * OSC_NS);
   endfunction
   task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic give_verdict();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic tmo(input int n);
      if (n >= 9000) begin
         n_fail++;
         give_verdict();
      end
   endtask
   task automatic axi_wr(input logic [3:0] a, input logic [7:0] dv, output logic [1:0] rs);
      logic ta, tw, da, dw;
      int n;
      da = 1'b0;
      dw = 1'b0;
      n = 0;
      s_axi_awaddr_in <= a;
      s_axi_wdata_in <= {24'h0, dv};
      s_axi_awvalid_in <= 1'b1;
      s_axi_wvalid_in <= 1'b1;
      while (!(da && dw) && n < 9000) begin
         @(negedge clk_in);
         ta = !da && s_axi_awready_out;
         tw = !dw && s_axi_wready_out;
         @(posedge clk_in);
         if (ta) s_axi_awvalid_in <= 1'b0;
         if (tw) s_axi_wvalid_in <= 1'b0;
         da = da | ta;
         dw = dw | tw;
         n++;
      end
      ta = 1'b0;
      while (!ta && n < 9000) begin
         @(negedge clk_in);
         ta = s_axi_bvalid_out;
         rs = s_axi_bresp_out;
         @(posedge clk_in);
         n++;
      end
      tmo(n);
   endtask
   task automatic axi_rd(input logic [3:0] a, output logic [31:0] dv, output logic [1:0] rs);
      logic t;
      int n;
      t = 1'b0;
      n = 0;
      s_axi_araddr_in <= a;
      s_axi_arvalid_in <= 1'b1;
      while (!t && n < 9000) begin
         @(negedge clk_in);
         t = s_axi_arready_out;
         @(posedge clk_in);
         n++;
      end
      s_axi_arvalid_in <= 1'b0;
      t = 1'b0;
      while (!t && n < 9000) begin
         @(negedge clk_in);
         t = s_axi_rvalid_out;
         dv = s_axi_rdata_out;
         rs = s_axi_rresp_out;
         @(posedge clk_in);
         n++;
      end
      tmo(n);
   endtask
   task automatic wait_rst(output realtime t);
      int n;
      n = 0;
      while (wdt_reset_out !== 1'b1 && n < 9000) begin
         @(negedge clk_in);
         n++;
      end
      t = $realtime;
      @(negedge clk_in);
      // hand back on a rising edge so the next bus call starts there
      @(posedge clk_in);
      tmo(n);
   endtask
   task automatic kick();
      kick_one <= 1'b1;
      @(posedge clk_in);
      kick_one <= 1'b0;
   endtask
   initial begin
      clk_in = 1'b0;
      {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_arvalid_in, kick_en, kick_one} = '0;
      {s_axi_awaddr_in, s_axi_araddr_in, s_axi_awprot_in, s_axi_arprot_in} = '0;
      {arst_n_in, s_axi_wdata_in} = '0;
      {s_axi_bready_in, s_axi_rready_in, s_axi_wstrb_in} = 6'h3f;
      void'($urandom(32'h15a3));
      repeat (3) @(posedge clk_in);
      arst_n_in <= 1'b1;
      @(posedge clk_in);
      axi_rd(CTRL_OFFS, d, r);
      chk_val("ctrl reset", {24'h0, CTRL_RESET}, d);
      axi_rd(STAT_OFFS, d, r);
      chk_val("stat reset", 32'h0, d);
      axi_rd(4'h8, d, r);
      chk_val("rd unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
      chk_val("rd unmapped data", 32'h0, d);
      axi_wr(4'hc, 8'hff, r);
      chk_val("wr unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
      for (k = 0; k < 8; k++) begin
         axi_wr(CTRL_OFFS, {3'($urandom), 2'b00, 3'(k)}, r);
         axi_rd(CTRL_OFFS, d, r);
         chk_val("ctrl select", 32'(k), d);
      end
      repeat (3000) @(posedge clk_in);
      chk_val("resets while off", 32'h0, 32'(n_rst));
      for (k = 0; k < 8; k++) begin
         kick();
         repeat (20) @(posedge clk_in);
         axi_wr(CTRL_OFFS, 8'h08 | 8'(k), r);
         wait_rst(t0);
         wait_rst(t1);
         d = 32'(int'(t1 - t0));
         // oscillator sync jitter tolerated
         if (d + 8 >= exp_ns(k) && d <= exp_ns(k) + 8) d = exp_ns(k);
         chk_val("period", exp_ns(k), d);
         axi_wr(CTRL_OFFS, 8'h18 | 8'(k), r);
         axi_wr(CTRL_OFFS, 8'(k), r);
      end
      axi_rd(CTRL_OFFS, d, r);
      chk_val("ctrl disabled", 32'h7, d);
      axi_rd(STAT_OFFS, d, r);
      chk_val("stat flag", 32'h1, d & 32'h1);
      axi_wr(STAT_OFFS, 8'h01, r);
      axi_rd(STAT_OFFS, d, r);
      chk_val("stat cleared", 32'h0, d & 32'h1);
      k = n_rst;
      axi_wr(CTRL_OFFS, 8'h00, r);
      repeat (300) @(posedge clk_in);
      chk_val("resets after off", 32'(k), 32'(n_rst));
      kick();
      axi_wr(CTRL_OFFS, 8'h08, r);
      axi_wr(CTRL_OFFS, 8'h18, r);
      repeat (8) @(posedge clk_in);
      axi_rd(CTRL_OFFS, d, r);
      chk_val("unlock expired", 32'h08, d);
      axi_wr(CTRL_OFFS, 8'h00, r);
      axi_rd(CTRL_OFFS, d, r);
      chk_val("enable kept", 32'h08, d);
      kick_en <= 1'b1;
      // first kick and its crossing may lag a full gap plus a round trip
      repeat (60) @(posedge clk_in);
      k = n_rst;
      repeat (400) @(posedge clk_in);
      chk_val("resets while kicked", 32'(k), 32'(n_rst));
      kick_en <= 1'b0;
      wait_rst(t0);
      chk_val("reset after kicks", 32'(k + 1), 32'(n_rst));
      give_verdict();
   end
endmodule
`default_nettype wire
